// File: hw/setpoint_pkg.sv
package setpoint_pkg;

    // Clock and timing
    localparam int CLK_MHZ        = 125;
    localparam int DEBOUNCE_US    = 1000;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
    localparam int RAMP_TICK_MS   = 1000;
    localparam int RAMP_TICK_CYC  = RAMP_TICK_MS * 1000 * CLK_MHZ;
    localparam int BLINK_BIT      = 25;
    localparam int DB_W           = 17;
    localparam int TICK_W         = 27;

    // Register offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] MSP_COUNT_OFS = 8'h04;
    localparam logic [7:0] ASSIGN_OFS    = 8'h08;
    localparam logic [7:0] SP0_OFS       = 8'h10;
    localparam logic [7:0] SP1_OFS       = 8'h14;
    localparam logic [7:0] SP2_OFS       = 8'h18;
    localparam logic [7:0] SP3_OFS       = 8'h1C;
    localparam logic [7:0] LOCAL_SP_OFS  = 8'h20;
    localparam logic [7:0] DISPLAY_OFS   = 8'h24;
    localparam logic [7:0] SP_HI_OFS     = 8'h28;
    localparam logic [7:0] SP_LO_OFS     = 8'h2C;
    localparam logic [7:0] EXT_HI_OFS    = 8'h30;
    localparam logic [7:0] EXT_LO_OFS    = 8'h34;
    localparam logic [7:0] RAMP_OFS      = 8'h38;
    localparam logic [7:0] STATUS_OFS    = 8'h3C;
    localparam logic [7:0] ACTIVE_OFS    = 8'h40;
    localparam logic [7:0] EXT_MON_OFS   = 8'h44;

    // Control register bits
    localparam int CTRL_EXT_EN  = 0;
    localparam int CTRL_MODE_EN = 1;
    localparam int CTRL_TRACK   = 2;
    localparam int CTRL_REMOTE  = 3;
    localparam int CTRL_STOP    = 4;
    localparam int CTRL_MANUAL  = 5;

    // Assignment field positions
    localparam int ASSIGN1_POS  = 0;
    localparam int ASSIGN2_POS  = 4;

    // Reset values
    localparam logic [15:0] SP_HI_RST  = 16'h03E8;
    localparam logic [15:0] SP_LO_RST  = 16'h0000;
    localparam logic [15:0] SP_RST     = 16'h0000;

    // External input span, tenths of a percent
    localparam int EXT_SPAN     = 1000;
    localparam int EXT_PCT_MIN  = -100;
    localparam int EXT_PCT_MAX  = 1100;

    typedef enum logic [1:0] {
        FN_NONE,
        FN_STOP,
        FN_HAND,
        FN_EXT
    } event_func_t;

endpackage

// File: hw/setpoint_source_select.sv
// Operation
// RULE1: four event functions: multi, stop, hand, mode
// RULE2: count 1 uses input 1, 2 both
// RULE3: free inputs use assignment; one unit disables
// RULE4: assignment: none, stop, manual, remote
// RULE5: index is input1 plus twice input2
// RULE6: stored set point writes refused without multi
// RULE7: display write lands in selected stored value
// RULE8: index change ramps when ramp enabled
// RULE9: stop and manual follow assigned input level
// RULE10: stop input halts, lights lamp, sets parameter
// RULE11: manual input enters manual, lights lamp
// RULE12: mode input acts only with enable on
// RULE13: mode input selects external or internal source
// RULE14: external set point needs its enable
// RULE15: scale external input between external limits
// RULE16: out of range clamps, flags, blinks lamp
// RULE17: out of range drives error output, error value
// RULE18: limiter change forces external limits too
// RULE19: multi mode internal source is selected value
// RULE20: mode parameter picks source, lights remote lamp
// RULE21: tracking copies in-use value on return local
// RULE22: switch to external ramps when enabled
// RULE23: ramp rate zero disables ramping
// RULE24: auto-tune freezes external input and set point
// RULE25: event inputs synchronised and debounced
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
module setpoint_source_select
    import setpoint_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES  = DEBOUNCE_CYC,
    parameter int RAMP_TICK_CYCLES = RAMP_TICK_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Register port
    input  wire logic [7:0]         addr,
    input  wire logic [31:0]        wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic      [31:0]        rdata,
    // Contacts and option strap
    input  wire logic [1:0]         event_in,
    input  wire logic               dual_unit,
    // External set point, tenths of percent of span
    input  wire logic signed [15:0] ext_pct,
    input  wire logic               ext_valid,
    input  wire logic               tuning,
    // Controller state
    output logic signed [15:0]      setpoint,
    output logic [1:0]              sp_index,
    output logic                    control_stop,
    output logic                    manual_mode,
    output logic                    remote_active,
    output logic                    ext_error,
    output logic                    error_mv_select,
    // Lamps
    output logic                    stop_lamp,
    output logic                    hand_lamp,
    output logic                    remote_lamp
);

    typedef struct packed {
        logic [1:0]            ev_s1;
        logic [1:0]            ev_s2;
        logic [1:0]            ev_db;
        logic [1:0][DB_W-1:0]  db_cnt;
        logic                  du_s1;
        logic                  du_s2;
        logic                  ext_en;
        logic                  mode_en;
        logic                  track;
        logic                  remote;
        logic                  stop;
        logic                  manual;
        logic [1:0]            msp_count;
        logic [1:0]            assign1;
        logic [1:0]            assign2;
        logic [3:0][15:0]      sp;
        logic [15:0]           local_sp;
        logic [15:0]           sp_hi;
        logic [15:0]           sp_lo;
        logic [15:0]           ext_hi;
        logic [15:0]           ext_lo;
        logic [15:0]           ramp_rate;
        logic [TICK_W-1:0]     tick_cnt;
        logic [15:0]           ramp_sp;
        logic [15:0]           ext_sp;
        logic                  ext_err;
        logic                  tuning_d;
        logic [15:0]           tune_sp;
        logic [BLINK_BIT:0]    blink_cnt;
        logic [31:0]           rdata;
    } state_t;
    state_t state_reg;
    state_t state_next;

    function automatic logic signed [15:0] clamp_sp(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        clamp_sp = (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    function automatic logic [1:0] input_func(
        input logic       used,
        input logic       units_two,
        input logic [1:0] code
    );
        // Assignment is meaningless with a single option unit
        input_func = (used || !units_two) ? FN_NONE : code;
    endfunction

    logic [1:0]         idx;
    logic [1:0]         fn1;
    logic [1:0]         fn2;
    logic               stop_asg;
    logic               stop_lvl;
    logic               hand_asg;
    logic               hand_lvl;
    logic               mode_asg;
    logic               mode_lvl;
    logic signed [15:0] internal_sp;
    logic signed [15:0] target;
    logic signed [31:0] span;
    logic signed [31:0] scaled;
    logic signed [16:0] diff;
    logic               tick;
    logic               leave_remote;
    logic               remote_now;

    always_comb begin
        state_next = state_reg;
        idx = 2'h0;
        case (state_reg.msp_count)                           // [RULE5]
            2'h1:    idx = {1'b0, state_reg.ev_db[0]};
            2'h2:    idx = state_reg.ev_db;
            default: idx = 2'h0;
        endcase
        // [RULE1] [RULE2] [RULE3] [RULE4]
        fn1 = input_func(state_reg.msp_count != 2'h0, state_reg.du_s2,
                         state_reg.assign1);
        fn2 = input_func(state_reg.msp_count == 2'h2, state_reg.du_s2,
                         state_reg.assign2);
        stop_asg = (fn1 == FN_STOP) || (fn2 == FN_STOP);
        stop_lvl = ((fn1 == FN_STOP) && state_reg.ev_db[0]) ||
                   ((fn2 == FN_STOP) && state_reg.ev_db[1]);
        hand_asg = (fn1 == FN_HAND) || (fn2 == FN_HAND);
        hand_lvl = ((fn1 == FN_HAND) && state_reg.ev_db[0]) ||
                   ((fn2 == FN_HAND) && state_reg.ev_db[1]);
        mode_asg = ((fn1 == FN_EXT) || (fn2 == FN_EXT)) &&
                   state_reg.mode_en;                        // [RULE12]
        mode_lvl = ((fn1 == FN_EXT) && state_reg.ev_db[0]) ||
                   ((fn2 == FN_EXT) && state_reg.ev_db[1]);

        // Synchronisers and debounce
        state_next.ev_s1 = event_in;
        state_next.ev_s2 = state_reg.ev_s1;
        state_next.du_s1 = dual_unit;
        state_next.du_s2 = state_reg.du_s1;
        for (int i = 0; i < 2; i++) begin                    // [RULE25]
            if (state_reg.ev_s2[i] == state_reg.ev_db[i]) begin
                state_next.db_cnt[i] = '0;
            end else if (state_reg.db_cnt[i] ==
                         DB_W'(DEBOUNCE_CYCLES - 1)) begin
                state_next.db_cnt[i] = '0;
                state_next.ev_db[i] = state_reg.ev_s2[i];
            end else begin
                state_next.db_cnt[i] = state_reg.db_cnt[i] + 1'b1;
            end
        end

        // Register writes
        if (wr) begin
            case (addr)
                CTRL_OFS: begin
                    state_next.ext_en  = wdata[CTRL_EXT_EN];
                    state_next.mode_en = wdata[CTRL_MODE_EN];
                    state_next.track   = wdata[CTRL_TRACK];
                    state_next.remote  = wdata[CTRL_REMOTE];
                    state_next.stop    = wdata[CTRL_STOP];
                    state_next.manual  = wdata[CTRL_MANUAL];
                end
                MSP_COUNT_OFS: begin
                    if (wdata[1:0] != 2'h3) begin
                        state_next.msp_count = wdata[1:0];
                    end
                end
                ASSIGN_OFS: begin
                    state_next.assign1 = wdata[ASSIGN1_POS +: 2];
                    state_next.assign2 = wdata[ASSIGN2_POS +: 2];
                end
                SP0_OFS, SP1_OFS, SP2_OFS, SP3_OFS: begin
                    if (state_reg.msp_count != 2'h0) begin   // [RULE6]
                        state_next.sp[addr[3:2]] = clamp_sp(wdata[15:0],
                            state_reg.sp_lo, state_reg.sp_hi);
                    end
                end
                LOCAL_SP_OFS: state_next.local_sp = clamp_sp(wdata[15:0],
                    state_reg.sp_lo, state_reg.sp_hi);
                DISPLAY_OFS: begin
                    if (state_reg.msp_count != 2'h0) begin   // [RULE7]
                        state_next.sp[idx] = clamp_sp(wdata[15:0],
                            state_reg.sp_lo, state_reg.sp_hi);
                    end else begin
                        state_next.local_sp = clamp_sp(wdata[15:0],
                            state_reg.sp_lo, state_reg.sp_hi);
                    end
                end
                SP_HI_OFS: begin
                    state_next.sp_hi  = wdata[15:0];
                    state_next.ext_hi = wdata[15:0];         // [RULE18]
                    state_next.ext_lo = state_reg.sp_lo;
                end
                SP_LO_OFS: begin
                    state_next.sp_lo  = wdata[15:0];
                    state_next.ext_lo = wdata[15:0];         // [RULE18]
                    state_next.ext_hi = state_reg.sp_hi;
                end
                EXT_HI_OFS: state_next.ext_hi = wdata[15:0];
                EXT_LO_OFS: state_next.ext_lo = wdata[15:0];
                RAMP_OFS:   state_next.ramp_rate = wdata[15:0];
                default: ;
            endcase
        end

        // Event inputs override key and host settings
        if (stop_asg) begin
            state_next.stop = stop_lvl;                      // [RULE9] [RULE10]
        end
        if (hand_asg) begin
            state_next.manual = hand_lvl;                    // [RULE9] [RULE11]
        end
        if (mode_asg) begin
            state_next.remote = mode_lvl;                    // [RULE13]
        end
        if (!state_next.ext_en) begin
            state_next.remote = 1'b0;                        // [RULE14]
        end

        // External input scaling, frozen during auto-tune
        span = 32'(signed'(state_reg.ext_hi)) - 32'(signed'(state_reg.ext_lo));
        scaled = 32'(signed'(state_reg.ext_lo)) +
                 (span * 32'(ext_pct)) / EXT_SPAN;           // [RULE15]
        if (ext_valid && !tuning) begin                      // [RULE24]
            if (ext_pct < 16'(EXT_PCT_MIN)) begin            // [RULE16]
                state_next.ext_err = 1'b1;
                state_next.ext_sp  = state_reg.ext_lo;
            end else if (ext_pct > 16'(EXT_PCT_MAX)) begin
                state_next.ext_err = 1'b1;
                state_next.ext_sp  = state_reg.ext_hi;
            end else begin
                state_next.ext_err = 1'b0;
                state_next.ext_sp  = scaled[15:0];
            end
        end

        // Source selection
        remote_now = state_reg.remote && state_reg.ext_en;   // [RULE20]
        internal_sp = (state_reg.msp_count != 2'h0) ?
                      signed'(state_reg.sp[idx]) :
                      signed'(state_reg.local_sp);           // [RULE19]
        target = remote_now ? signed'(state_reg.ext_sp) : internal_sp;
        state_next.tuning_d = tuning;
        if (tuning && !state_reg.tuning_d) begin
            state_next.tune_sp = target;
        end
        if (tuning && state_reg.tuning_d) begin
            target = signed'(state_reg.tune_sp);             // [RULE24]
        end

        // Tracking on return to the internal source
        leave_remote = remote_now && !(state_next.remote &&
                                       state_next.ext_en);
        if (leave_remote && state_reg.track) begin           // [RULE21]
            if (state_reg.msp_count != 2'h0) begin
                state_next.sp[idx] = state_reg.ramp_sp;
            end else begin
                state_next.local_sp = state_reg.ramp_sp;
            end
        end

        // Ramp toward target; bypassed when stopped or rate is zero
        tick = state_reg.tick_cnt == TICK_W'(RAMP_TICK_CYCLES - 1);
        state_next.tick_cnt = tick ? '0 : state_reg.tick_cnt + 1'b1;
        diff = 17'(target) - 17'(signed'(state_reg.ramp_sp));
        if (state_reg.ramp_rate == 16'h0000 || state_reg.stop) begin
            state_next.ramp_sp = target;                     // [RULE23]
        end else if (tick) begin                             // [RULE8] [RULE22]
            if (diff > 17'(signed'({1'b0, state_reg.ramp_rate}))) begin
                state_next.ramp_sp = state_reg.ramp_sp + state_reg.ramp_rate;
            end else if (-diff > 17'(signed'({1'b0,
                                             state_reg.ramp_rate}))) begin
                state_next.ramp_sp = state_reg.ramp_sp - state_reg.ramp_rate;
            end else begin
                state_next.ramp_sp = target;
            end
        end
        state_next.blink_cnt = state_reg.blink_cnt + 1'b1;

        // Read port, data valid the following cycle only
        state_next.rdata = 32'h0000_0000;
        if (rd) begin
            case (addr)
                CTRL_OFS: state_next.rdata = {26'h0, state_reg.manual,
                    state_reg.stop, state_reg.remote, state_reg.track,
                    state_reg.mode_en, state_reg.ext_en};
                MSP_COUNT_OFS: state_next.rdata = {30'h0, state_reg.msp_count};
                ASSIGN_OFS: state_next.rdata = {26'h0, state_reg.assign2,
                    2'h0, state_reg.assign1};
                SP0_OFS, SP1_OFS, SP2_OFS, SP3_OFS:
                    state_next.rdata = {16'h0, state_reg.sp[addr[3:2]]};
                LOCAL_SP_OFS: state_next.rdata = {16'h0, state_reg.local_sp};
                DISPLAY_OFS: state_next.rdata = {16'h0, internal_sp};
                SP_HI_OFS:  state_next.rdata = {16'h0, state_reg.sp_hi};
                SP_LO_OFS:  state_next.rdata = {16'h0, state_reg.sp_lo};
                EXT_HI_OFS: state_next.rdata = {16'h0, state_reg.ext_hi};
                EXT_LO_OFS: state_next.rdata = {16'h0, state_reg.ext_lo};
                RAMP_OFS:   state_next.rdata = {16'h0, state_reg.ramp_rate};
                STATUS_OFS: state_next.rdata = {22'h0, idx, 1'b0,
                    state_reg.ev_db, state_reg.du_s2, state_reg.manual,
                    state_reg.stop, remote_now, state_reg.ext_err};
                ACTIVE_OFS:  state_next.rdata = {16'h0, state_reg.ramp_sp};
                EXT_MON_OFS: state_next.rdata = {16'h0, state_reg.ext_sp};
                default:     state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg           <= '0;
            state_reg.sp_hi     <= SP_HI_RST;
            state_reg.sp_lo     <= SP_LO_RST;
            state_reg.ext_hi    <= SP_HI_RST;
            state_reg.ext_lo    <= SP_LO_RST;
            state_reg.local_sp  <= SP_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata           = state_reg.rdata;
    assign setpoint        = state_reg.ramp_sp;
    assign sp_index        = idx;
    assign control_stop    = state_reg.stop;
    assign manual_mode     = state_reg.manual;
    assign remote_active   = state_reg.remote && state_reg.ext_en;
    // Error only counts while the external function is enabled
    assign ext_error       = state_reg.ext_err && state_reg.ext_en; // [RULE17]
    assign error_mv_select = ext_error && remote_active;     // [RULE17]
    assign stop_lamp       = state_reg.stop;
    assign hand_lamp       = state_reg.manual;
    assign remote_lamp     = remote_active && (!ext_error ||
                             state_reg.blink_cnt[BLINK_BIT]); // [RULE16]

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sp_write_refused_a: assert property ( // [RULE6]
        wr && addr == SP0_OFS && state_reg.msp_count == 2'h0 &&
        !(state_reg.track && remote_active) |=> $stable(state_reg.sp[0]))
        else $error("stored set point written without multi mode");
    index_map_a: assert property ( // [RULE5]
        state_reg.msp_count == 2'h2 |-> sp_index == state_reg.ev_db)
        else $error("set point index mismatch");
    stop_follow_a: assert property ( // [RULE9]
        stop_asg |=> control_stop == $past(stop_lvl))
        else $error("stop parameter not following input");
    manual_follow_a: assert property ( // [RULE11]
        hand_asg && hand_lvl |=> manual_mode && hand_lamp)
        else $error("manual input ignored");
    ext_clamp_a: assert property ( // [RULE16]
        ext_valid && !tuning && ext_pct > 16'(EXT_PCT_MAX) |=>
        state_reg.ext_sp == $past(state_reg.ext_hi) && state_reg.ext_err)
        else $error("external input not clamped high");
    limit_couple_a: assert property ( // [RULE18]
        wr && addr == SP_HI_OFS |=>
        state_reg.ext_hi == $past(wdata[15:0]) &&
        state_reg.ext_lo == state_reg.sp_lo)
        else $error("external limits not forced");
    ramp_off_a: assert property ( // [RULE23]
        state_reg.ramp_rate == 16'h0000 |=> setpoint == $past(target))
        else $error("set point ramped with rate zero");
    track_copy_a: assert property ( // [RULE21]
        leave_remote && state_reg.track && state_reg.msp_count == 2'h0
        |=> state_reg.local_sp == $past(setpoint))
        else $error("tracking did not copy set point");
    ext_gate_a: assert property ( // [RULE14]
        !state_reg.ext_en |-> !remote_active && !error_mv_select)
        else $error("external source active while disabled");

    stop_event_c: cover property (stop_asg && stop_lvl ##1 control_stop);
    remote_switch_c: cover property (!remote_active ##1 remote_active);
    ext_error_c: cover property (ext_error && remote_active);

endmodule

// File: test/contact_source_model.sv
`timescale 1ns/1ps
module contact_source_model (
    // Clock
    input  wire logic          clk,
    // Toward the block
    output logic [1:0]         event_in,
    output logic signed [15:0] ext_pct,
    output logic               ext_valid
);
    initial begin
        event_in  = 2'h0;
        ext_pct   = 16'h0000;
        ext_valid = 1'b0;
    end
    // Contacts move right after an edge and then hold
    task automatic set_contacts(input logic [1:0] lvl);
        @(posedge clk);
        event_in <= lvl;
    endtask
    // One sample; afterwards the bus shows junk, so stale reuse shows
    task automatic send_ext(input logic signed [15:0] pct);
        @(posedge clk);
        ext_pct   <= pct;
        ext_valid <= 1'b1;
        @(posedge clk);
        ext_valid <= 1'b0;
        ext_pct   <= ~pct;
    endtask
endmodule

// File: test/test_setpoint_source_select.sv
`timescale 1ns/1ps
module test_setpoint_source_select
    import setpoint_pkg::*;
;
    logic               clk;
    logic               rst_n;
    logic [7:0]         addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
    logic [31:0]        rdata;
    logic [1:0]         event_in;
    logic signed [15:0] ext_pct;
    logic               ext_valid;
    logic               dual_unit;
    logic               tuning;
    logic signed [15:0] setpoint;
    logic [1:0]         sp_index;
    logic               control_stop;
    logic               manual_mode;
    logic               remote_active;
    logic               ext_error;
    logic               error_mv_select;
    logic               stop_lamp;
    logic               hand_lamp;
    logic               remote_lamp;
    int                 err_count;
    int                 n_compared;
    logic [1:0]         c;

    setpoint_source_select #(
        .DEBOUNCE_CYCLES (4),
        .RAMP_TICK_CYCLES(8)
    ) i_setpoint_source_select (
        .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .event_in,
        .dual_unit, .ext_pct, .ext_valid, .tuning, .setpoint, .sp_index,
        .control_stop, .manual_mode, .remote_active, .ext_error,
        .error_mv_select, .stop_lamp, .hand_lamp, .remote_lamp
    );
    contact_source_model i_contact_source_model (
        .clk, .event_in, .ext_pct, .ext_valid
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // Contacts need sync plus debounce before they act
    task automatic contacts(input logic [1:0] lvl);
        i_contact_source_model.set_contacts(lvl);
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic close_out();
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        err_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        dual_unit = 1'b1;
        tuning = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(EXT_HI_OFS, 32'h000003E8);
        rd_chk(8'h80, 32'h00000000);
        wr_reg(SP0_OFS, 32'h00000064);
        rd_chk(SP0_OFS, 32'h00000000);
        wr_reg(MSP_COUNT_OFS, 32'h00000002);
        for (int k = 0; k < 4; k++) begin
            wr_reg(SP0_OFS + 8'(4 * k), 32'(100 + 100 * k));
        end
        for (int k = 0; k < 4; k++) begin
            contacts(2'(k));
            chk({30'h0, sp_index}, 32'(k));
            chk(32'(setpoint), 32'(100 + 100 * k));
        end
        wr_reg(DISPLAY_OFS, 32'h000001F4);
        rd_chk(SP3_OFS, 32'h000001F4);
        wr_reg(MSP_COUNT_OFS, 32'h00000001);
        contacts(2'h2);
        chk({30'h0, sp_index}, 32'h00000000);
        for (int k = 1; k < 4; k++) begin
            c = 2'(k);
            wr_reg(ASSIGN_OFS, {26'h0, c, 4'h0});
            wr_reg(CTRL_OFS, 32'h00000003);
            contacts(2'h2);
            chk({29'h0, control_stop, stop_lamp, c == 2'h1},
                {29'h0, {3{c == 2'h1}}});
            chk({30'h0, manual_mode, hand_lamp},
                {30'h0, {2{c == 2'h2}}});
            chk({30'h0, remote_active, remote_lamp},
                {30'h0, {2{c == 2'h3}}});
            rd_chk(CTRL_OFS, c == 2'h1 ? 32'h13 :
                   c == 2'h2 ? 32'h23 : 32'h0B);
            contacts(2'h0);
        end
        wr_reg(CTRL_OFS, 32'h00000001);
        contacts(2'h2);
        chk({31'h0, remote_active}, 32'h00000000);
        contacts(2'h0);
        wr_reg(ASSIGN_OFS, 32'h00000000);
        wr_reg(CTRL_OFS, 32'h0000000D);
        i_contact_source_model.send_ext(16'sd500);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(setpoint), 32'h000001F4);
        i_contact_source_model.send_ext(16'sd1200);
        repeat (2) @(posedge clk);
        #1;
        chk({30'h0, ext_error, error_mv_select}, 32'h00000003);
        rd_chk(EXT_MON_OFS, 32'h000003E8);
        i_contact_source_model.send_ext(16'sd250);
        wr_reg(CTRL_OFS, 32'h00000005);
        repeat (3) @(posedge clk);
        rd_chk(SP0_OFS, 32'h000000FA);
        wr_reg(CTRL_OFS, 32'h00000008);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, remote_active}, 32'h00000000);
        wr_reg(SP_HI_OFS, 32'h00000320);
        rd_chk(EXT_HI_OFS, 32'h00000320);
        // Ramp must not step straight to the new stored value
        wr_reg(RAMP_OFS, 32'h0000000A);
        contacts(2'h1);
        chk({31'h0, setpoint > 16'sd200}, 32'h00000001);
        repeat (60) @(posedge clk);
        #1;
        chk(32'(setpoint), 32'h000000C8);
        wr_reg(CTRL_OFS, 32'h00000009);
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, setpoint < 16'sd250}, 32'h00000001);
        repeat (60) @(posedge clk);
        #1;
        chk(32'(setpoint), 32'h000000FA);
        wr_reg(RAMP_OFS, 32'h00000000);
        tuning <= 1'b1;
        i_contact_source_model.send_ext(16'sd500);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(setpoint), 32'h000000FA);
        @(posedge clk);
        tuning <= 1'b0;
        i_contact_source_model.send_ext(16'sd500);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(setpoint), 32'h00000190);
        // Single option unit: assignments have no effect
        @(posedge clk);
        dual_unit <= 1'b0;
        wr_reg(ASSIGN_OFS, 32'h00000010);
        contacts(2'h2);
        chk({31'h0, control_stop}, 32'h00000000);
        @(posedge clk);
        dual_unit <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({31'h0, control_stop}, 32'h00000001);
        rd_chk(STATUS_OFS, 32'h00000056);
        close_out();
    end
endmodule
